// file: rtl/vscg_bank.v
`timescale 1ns/100ps
`include "vscg_regs.vh"

// four configuration words with a registered read port
module vscg_bank (
    mclk,
    rst_n,
    wr_en,
    wr_sel,
    wr_data,
    rd_sel,
    rd_data,
    en_word,
    cmp_word,
    swp_word,
    addr_word
);
    input  wire        mclk;
    input  wire        rst_n;
    input  wire        wr_en;
    input  wire [1:0]  wr_sel;
    input  wire [31:0] wr_data;
    input  wire [1:0]  rd_sel;
    output reg  [31:0] rd_data;
    output wire [31:0] en_word;
    output wire [31:0] cmp_word;
    output wire [31:0] swp_word;
    output wire [31:0] addr_word;

    reg [31:0] mem_r [0:3];
    integer    i;

    assign addr_word = mem_r[0];
    assign en_word   = mem_r[1];
    assign cmp_word  = mem_r[2];
    assign swp_word  = mem_r[3];

    // write port and registered read
    always @(posedge mclk) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                mem_r[i] <= `VSCG_RST_WORD;
            end
            rd_data <= `VSCG_RST_WORD;
        end else begin
            if (wr_en) begin
                mem_r[wr_sel] <= wr_data;
            end
            rd_data <= mem_r[rd_sel];
        end
    end
endmodule // vscg_bank

// file: rtl/vscg_regs.vh
`ifndef VSCG_REGS_VH
`define VSCG_REGS_VH

// register byte offsets
`define VSCG_OFF_CTL        12'h170
`define VSCG_OFF_ADDR       12'h174
`define VSCG_OFF_EN         12'h178
`define VSCG_OFF_CMP        12'h17c
`define VSCG_OFF_SWP        12'h180
`define VSCG_OFF_STAT       12'h184

// control field positions and codes
`define VSCG_CTL_SEL_HI     1
`define VSCG_CTL_SEL_LO     0
`define VSCG_CTL_SPACE      2
`define VSCG_SEL_OFF        2'h0
`define VSCG_SEL_RMW        2'h1
`define VSCG_SEL_ADOH       2'h2

// address compare field
`define VSCG_ADDR_HI        31
`define VSCG_ADDR_LO        2

// reset values
`define VSCG_RST_CTL        3'h0
`define VSCG_RST_WORD       32'h0000_0000

`endif

// file: rtl/vscg_top.v
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "vscg_regs.vh"

// Behaviour
// - a pci access to the programmed address starts a special cycle
// - read-modify-write starts only on a pci read
// - address-only cycle starts on a pci read or a pci write
// - cycle select 00 off, 01 read-modify-write, 10 address-only, 11 reserved
// - space select 0 memory, 1 i/o, checked for read-modify-write only
// - match compares pci address bits 31:2 with the programmed address
// - a matching access never gets a 64-bit acknowledge
// - only enabled bit positions take part in compare and swap
// - read data compared with compare value over enabled bits
// - on full match write swap value into enabled bits only
module vscg_top (
    mclk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    pci_req,
    pci_addr,
    pci_write,
    pci_io,
    pci_match,
    pci_ack64_ok,
    pci_done,
    pci_rdata,
    vme_req,
    vme_rmw,
    vme_adoh,
    vme_write,
    vme_addr,
    vme_wdata,
    vme_own,
    vme_ack,
    vme_rdata
);
    input  wire        mclk;
    input  wire        rst_n;
    input  wire [11:0] reg_addr;
    input  wire [31:0] reg_wdata;
    input  wire        reg_wr;
    input  wire        reg_rd;
    output reg  [31:0] reg_rdata;
    input  wire        pci_req;      // address phase strobe
    input  wire [31:0] pci_addr;
    input  wire        pci_write;
    input  wire        pci_io;       // 1 = i/o space
    output wire        pci_match;
    output wire        pci_ack64_ok;
    output reg         pci_done;     // one-cycle completion pulse
    output reg  [31:0] pci_rdata;
    output wire        vme_req;      // phase request level
    output reg         vme_rmw;      // type of cycle in progress
    output reg         vme_adoh;
    output reg         vme_write;
    output reg  [31:0] vme_addr;
    output reg  [31:0] vme_wdata;
    output reg         vme_own;      // bus ownership held
    input  wire        vme_ack;
    input  wire [31:0] vme_rdata;

    // one-hot sequencer states
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_RD   = 5'b00010;
    localparam [4:0] ST_CMP  = 5'b00100;
    localparam [4:0] ST_WR   = 5'b01000;
    localparam [4:0] ST_ADO  = 5'b10000;

    // sequencer, control and read source state
    reg  [4:0]  state_r;
    reg  [4:0]  state_nxt;
    reg  [2:0]  ctl_r;
    reg  [31:0] rd_hold_r;
    reg         cmp_ok_r;
    reg         rd_ctl_r;
    reg         rd_stat_r;
    reg         rd_bank_r;
    reg         wr_bank;
    reg  [1:0]  bank_wsel;
    reg  [1:0]  bank_rsel;
    // configuration words and decode results
    wire [31:0] bank_rdata;
    wire [31:0] en_word;
    wire [31:0] cmp_word;
    wire [31:0] swp_word;
    wire [31:0] addr_word;
    wire        addr_hit;
    wire        space_ok;
    wire        start_rmw;
    wire        start_ado;
    wire        idle;

    // masked equality of two words
    function masked_eq;
        input [31:0] a;
        input [31:0] b;
        input [31:0] m;
        begin
            masked_eq = ((a ^ b) & m) == 32'h0000_0000;
        end
    endfunction

    // merge new bits into old over the mask
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [31:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    // address, enable, compare and swap words
    vscg_bank u_bank (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .wr_en     (wr_bank),
        .wr_sel    (bank_wsel),
        .wr_data   (reg_wdata),
        .rd_sel    (bank_rsel),
        .rd_data   (bank_rdata),
        .en_word   (en_word),
        .cmp_word  (cmp_word),
        .swp_word  (swp_word),
        .addr_word (addr_word)
    );

    // register write and read decode
    always @* begin
        wr_bank   = 1'b0;
        bank_wsel = 2'd0;
        bank_rsel = 2'd0;
        if (reg_addr == `VSCG_OFF_ADDR) begin
            wr_bank   = reg_wr;
            bank_wsel = 2'd0;
            bank_rsel = 2'd0;
        end else if (reg_addr == `VSCG_OFF_EN) begin
            wr_bank   = reg_wr;
            bank_wsel = 2'd1;
            bank_rsel = 2'd1;
        end else if (reg_addr == `VSCG_OFF_CMP) begin
            wr_bank   = reg_wr;
            bank_wsel = 2'd2;
            bank_rsel = 2'd2;
        end else if (reg_addr == `VSCG_OFF_SWP) begin
            wr_bank   = reg_wr;
            bank_wsel = 2'd3;
            bank_rsel = 2'd3;
        end
    end

    // control register and read source tracking
    always @(posedge mclk) begin
        if (!rst_n) begin
            ctl_r     <= `VSCG_RST_CTL;
            rd_ctl_r  <= 1'b0;
            rd_stat_r <= 1'b0;
            rd_bank_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `VSCG_OFF_CTL) begin
                ctl_r <= reg_wdata[2:0];
            end
            rd_ctl_r  <= reg_rd && (reg_addr == `VSCG_OFF_CTL);
            rd_stat_r <= reg_rd && (reg_addr == `VSCG_OFF_STAT);
            rd_bank_r <= reg_rd && (reg_addr == `VSCG_OFF_ADDR || reg_addr == `VSCG_OFF_EN
                         || reg_addr == `VSCG_OFF_CMP || reg_addr == `VSCG_OFF_SWP);
        end
    end

    // read data mux; unmapped reads return zero
    always @* begin
        if (rd_ctl_r) begin
            reg_rdata = {29'h0000_0000, ctl_r};
        end else if (rd_stat_r) begin
            reg_rdata = {30'h0000_0000, cmp_ok_r, ~idle};
        end else if (rd_bank_r) begin
            reg_rdata = bank_rdata;
        end else begin
            reg_rdata = `VSCG_RST_WORD;
        end
    end

    assign addr_hit = pci_addr[`VSCG_ADDR_HI:`VSCG_ADDR_LO]
                      == addr_word[`VSCG_ADDR_HI:`VSCG_ADDR_LO];
    assign space_ok = pci_io == ctl_r[`VSCG_CTL_SPACE];
    assign pci_match = addr_hit && (
        (ctl_r[1:0] == `VSCG_SEL_RMW && space_ok) ||
        (ctl_r[1:0] == `VSCG_SEL_ADOH));
    assign pci_ack64_ok = ~pci_match;

    // sequencer free for a new start
    assign idle = state_r == ST_IDLE;
    assign start_rmw = idle && pci_req && pci_match && !pci_write
                       && ctl_r[1:0] == `VSCG_SEL_RMW;
    assign start_ado = idle && pci_req && pci_match && ctl_r[1:0] == `VSCG_SEL_ADOH;
    // phase request stands until the slave acknowledges
    assign vme_req   = state_r == ST_RD || state_r == ST_WR || state_r == ST_ADO;

    // next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_rmw) begin
                    state_nxt = ST_RD;
                end else if (start_ado) begin
                    state_nxt = ST_ADO;
                end
            end
            ST_RD: begin
                if (vme_ack) begin
                    state_nxt = ST_CMP;
                end
            end
            ST_CMP: begin
                if (cmp_ok_r) begin
                    state_nxt = ST_WR;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WR: begin
                if (vme_ack) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ADO: begin
                if (vme_ack) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // cycle datapath and vme outputs
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_r   <= ST_IDLE;
            rd_hold_r <= `VSCG_RST_WORD;
            cmp_ok_r  <= 1'b0;
            pci_done  <= 1'b0;
            pci_rdata <= `VSCG_RST_WORD;
            vme_rmw   <= 1'b0;
            vme_adoh  <= 1'b0;
            vme_write <= 1'b0;
            vme_addr  <= `VSCG_RST_WORD;
            vme_wdata <= `VSCG_RST_WORD;
            vme_own   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            pci_done <= 1'b0;
            // latch cycle type and word address on a start
            if (start_rmw || start_ado) begin
                vme_addr  <= {pci_addr[31:2], 2'b00};
                vme_rmw   <= start_rmw;
                vme_adoh  <= start_ado;
                vme_write <= 1'b0;
                vme_own   <= 1'b1;
            end
            if (state_r == ST_RD && vme_ack) begin
                rd_hold_r <= vme_rdata;
                pci_rdata <= vme_rdata;
                cmp_ok_r  <= masked_eq(vme_rdata, cmp_word, en_word);
            end
            if (state_r == ST_CMP) begin
                if (cmp_ok_r) begin
                    vme_write <= 1'b1;
                    vme_wdata <= merge(rd_hold_r, swp_word, en_word);
                end else begin
                    vme_own  <= 1'b0;
                    vme_rmw  <= 1'b0;
                    pci_done <= 1'b1;
                end
            end
            // last phase acknowledged: release the bus and report
            if ((state_r == ST_WR || state_r == ST_ADO) && vme_ack) begin
                vme_own   <= 1'b0;
                vme_rmw   <= 1'b0;
                vme_adoh  <= 1'b0;
                vme_write <= 1'b0;
                pci_done  <= 1'b1;
            end
        end
    end
endmodule // vscg_top

// file: tb/tb_vscg_top.sv
`timescale 1ns/100ps
`include "vscg_regs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("FAIL %0t %h %h", $time, a, e); end end

module tb_vscg_top;
    reg         mclk, rst_n, reg_wr, reg_rd, pci_req, pci_write, pci_io, ld;
    reg  [11:0] reg_addr;
    reg  [31:0] reg_wdata, pci_addr, ld_val;
    reg  [3:0]  lat;
    wire [31:0] reg_rdata, pci_rdata, vme_addr, vme_wdata, vme_rdata, mem;
    wire        pci_match, pci_ack64_ok, pci_done, vme_req, vme_ack;
    wire        vme_rmw, vme_adoh, vme_write, vme_own;
    integer     bad_count, checks_done, i;
    localparam [31:0] SA = 32'h1234_5670;

    vscg_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pci_req(pci_req),
        .pci_addr(pci_addr), .pci_write(pci_write), .pci_io(pci_io), .pci_match(pci_match),
        .pci_ack64_ok(pci_ack64_ok), .pci_done(pci_done), .pci_rdata(pci_rdata),
        .vme_req(vme_req), .vme_rmw(vme_rmw), .vme_adoh(vme_adoh), .vme_write(vme_write),
        .vme_addr(vme_addr), .vme_wdata(vme_wdata), .vme_own(vme_own), .vme_ack(vme_ack),
        .vme_rdata(vme_rdata));
    vscg_vme_slave slv (.mclk(mclk), .rst_n(rst_n), .vme_req(vme_req), .vme_write(vme_write),
        .vme_wdata(vme_wdata), .lat(lat), .ld(ld), .ld_val(ld_val), .vme_ack(vme_ack),
        .vme_rdata(vme_rdata), .mem_r(mem));

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task results;
        begin
            $display("checks %0d mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'b1;
            @(posedge mclk);
            reg_wr    <= 1'b0;
        end
    endtask

    task rdc(input [11:0] a, input [31:0] e);
        begin
            @(posedge mclk);
            reg_addr <= a;
            reg_rd   <= 1'b1;
            @(posedge mclk);
            reg_rd   <= 1'b0;
            #1 `CHK(reg_rdata, e)
        end
    endtask

    // one pci address phase, then a bounded wait for completion
    task go(input [31:0] a, input w, input io, input exp);
        reg        seen;
        reg [31:0] va;
        begin
            @(posedge mclk);
            pci_addr  <= a;
            pci_write <= w;
            pci_io    <= io;
            pci_req   <= 1'b1;
            @(posedge mclk);
            pci_req   <= 1'b0;
            seen = 1'b0;
            va = {a[31:2], 2'b00};
            if (exp) `CHK(pci_ack64_ok, 1'b0)
            repeat (40) begin
                #1 if (vme_req === 1'b1) `CHK(vme_addr, va)
                if (vme_req === 1'b1) `CHK(vme_own, 1'b1)
                if (pci_done === 1'b1) seen = 1'b1;
                @(posedge mclk);
            end
            `CHK(seen, exp)
            if (exp && !seen) results();
        end
    endtask

    task t_regs;
        begin
            for (i = 0; i < 5; i = i + 1) rdc(12'h170 + 4 * i, 32'h0000_0000);
            for (i = 0; i < 5; i = i + 1) wr(12'h170 + 4 * i, 32'hffff_ffff);
            rdc(`VSCG_OFF_CTL, 32'h0000_0007);
            for (i = 1; i < 5; i = i + 1) rdc(12'h170 + 4 * i, 32'hffff_ffff);
            wr(12'h1f0, 32'h5a5a_5a5a);
            rdc(12'h1f0, 32'h0000_0000);
            wr(`VSCG_OFF_ADDR, SA);
        end
    endtask

    task t_rmw(input [31:0] init, input [31:0] en, input [31:0] cmp, input [31:0] swap_value,
               input [3:0] l);
        reg [31:0] exp;
        reg        m;
        begin
            wr(`VSCG_OFF_EN, en);
            wr(`VSCG_OFF_CMP, cmp);
            wr(`VSCG_OFF_SWP, swap_value);
            wr(`VSCG_OFF_CTL, {30'h0, `VSCG_SEL_RMW});
            @(posedge mclk);
            lat    <= l;
            ld_val <= init;
            ld     <= 1'b1;
            @(posedge mclk);
            ld     <= 1'b0;
            m = (((init ^ cmp) & en) == 32'h0000_0000);
            exp = m ? ((init & ~en) | (swap_value & en)) : init;
            go(SA, 1'b0, 1'b0, 1'b1);
            `CHK(pci_rdata, init)
            `CHK(mem, exp)
            rdc(`VSCG_OFF_STAT, {30'h0, m, 1'b0});
        end
    endtask

    task t_adoh;
        begin
            wr(`VSCG_OFF_CTL, {29'h0, 1'b1, `VSCG_SEL_ADOH});
            go(SA, 1'b1, 1'b0, 1'b1);
            go(SA | 32'h0000_0003, 1'b0, 1'b1, 1'b1);
            `CHK(mem, 32'h0f0f_0f0f)
        end
    endtask

    task t_none;
        begin
            wr(`VSCG_OFF_CTL, 32'h0000_0000);
            go(SA, 1'b0, 1'b0, 1'b0);
            `CHK(pci_ack64_ok, 1'b1)
            wr(`VSCG_OFF_CTL, 32'h0000_0003);
            go(SA, 1'b0, 1'b0, 1'b0);
            wr(`VSCG_OFF_CTL, {30'h0, `VSCG_SEL_RMW});
            go(SA, 1'b1, 1'b0, 1'b0);
            `CHK(pci_ack64_ok, 1'b0)
            go(SA ^ 32'h0000_0004, 1'b0, 1'b0, 1'b0);
            `CHK(pci_ack64_ok, 1'b1)
            go(SA, 1'b0, 1'b1, 1'b0);
            `CHK(pci_ack64_ok, 1'b1)
            wr(`VSCG_OFF_CTL, {29'h0, 1'b1, `VSCG_SEL_RMW});
            go(SA, 1'b0, 1'b1, 1'b1);
        end
    endtask

    // reset in mid-run clears every register and disarms the generator
    task t_rst;
        begin
            @(posedge mclk);
            rst_n <= 1'b0;
            repeat (3) @(posedge mclk);
            rst_n <= 1'b1;
            for (i = 0; i < 6; i = i + 1) rdc(12'h170 + 4 * i, 32'h0000_0000);
            go(SA, 1'b0, 1'b0, 1'b0);
            `CHK(pci_ack64_ok, 1'b1)
        end
    endtask

    // reset, then the scenarios in turn
    initial begin
        bad_count = 0;
        checks_done = 0;
        rst_n = 1'b0;
        {reg_wr, reg_rd, pci_req, pci_write, pci_io, ld} = 6'h00;
        {reg_addr, reg_wdata, pci_addr, ld_val, lat} = 112'h0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs;
        t_rmw(32'hdead_beef, 32'hffff_0000, 32'hdead_0000, 32'h1234_5678, 4'h0);
        t_rmw(32'hdead_beef, 32'h0000_00ff, 32'h0000_0000, 32'hffff_ffff, 4'h3);
        t_rmw(32'h0f0f_0f0f, 32'h0000_0000, 32'hffff_ffff, 32'hffff_ffff, 4'h1);
        t_adoh;
        t_none;
        t_rst;
        results;
    end
endmodule // tb_vscg_top

// file: tb/vscg_top_assertions.sv
`timescale 1ns/100ps
// sequencing checks on the generator ports
module vscg_top_chk (
    input wire mclk,
    input wire rst_n,
    input wire pci_req,
    input wire pci_write,
    input wire pci_match,
    input wire pci_ack64_ok,
    input wire pci_done,
    input wire vme_req,
    input wire vme_rmw,
    input wire vme_adoh,
    input wire vme_write,
    input wire vme_own,
    input wire vme_ack
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // a matching read while idle
    sequence s_start;
        pci_req && pci_match && !pci_write && !vme_own;
    endsequence
    // end of the read phase of a read-modify-write
    sequence s_rd_end;
        vme_rmw && !vme_write && vme_req && vme_ack;
    endsequence

    chk_no_ack64: assert property (pci_match |-> !pci_ack64_ok)
        else $error("wide acknowledge offered on a match");
    chk_read_start: assert property (s_start |=> vme_req && vme_own)
        else $error("matching read did not start a cycle");
    chk_rmw_on_read: assert property ($rose(vme_rmw) |-> $past(pci_req && !pci_write))
        else $error("read-modify-write started without a read");
    chk_adoh_cause: assert property ($rose(vme_adoh) |-> $past(pci_req && pci_match))
        else $error("address-only cycle without a matching access");
    chk_type_excl: assert property (!(vme_rmw && vme_adoh))
        else $error("two cycle types at once");
    chk_rmw_hold: assert property (s_rd_end |=> vme_own && !vme_req ##1 (vme_own || pci_done))
        else $error("bus dropped between read and write");
    chk_wr_owned: assert property (vme_write |-> vme_own && vme_rmw)
        else $error("write phase without ownership");
    chk_wr_end: assert property (vme_write && vme_ack |=> pci_done && !vme_own && !vme_write)
        else $error("write phase did not complete");
    chk_adoh_end: assert property (vme_adoh && vme_ack |=> pci_done && !vme_own && !vme_adoh)
        else $error("address-only cycle did not complete");
endmodule // vscg_top_chk

bind vscg_top vscg_top_chk u_chk (.mclk(mclk), .rst_n(rst_n), .pci_req(pci_req),
    .pci_write(pci_write), .pci_match(pci_match), .pci_ack64_ok(pci_ack64_ok),
    .pci_done(pci_done), .vme_req(vme_req), .vme_rmw(vme_rmw), .vme_adoh(vme_adoh),
    .vme_write(vme_write), .vme_own(vme_own), .vme_ack(vme_ack));

// file: tb/vscg_vme_slave.sv
`timescale 1ns/100ps
// one-location vme slave with a programmable answer delay
module vscg_vme_slave (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        vme_req,
    input  wire        vme_write,
    input  wire [31:0] vme_wdata,
    input  wire [3:0]  lat,
    input  wire        ld,
    input  wire [31:0] ld_val,
    output reg         vme_ack,
    output wire [31:0] vme_rdata,
    output reg  [31:0] mem_r
);
    reg [3:0] cnt_r;

    // data lines show garbage outside the acknowledge cycle
    assign vme_rdata = vme_ack ? mem_r : ~mem_r;

    // count the delay, then acknowledge one cycle and store writes
    always @(posedge mclk) begin
        if (!rst_n) begin
            vme_ack <= 1'b0;
            cnt_r   <= 4'h0;
            mem_r   <= 32'h0000_0000;
        end else if (vme_req && !vme_ack && cnt_r >= lat) begin
            vme_ack <= 1'b1;
            cnt_r   <= 4'h0;
            if (vme_write)
                mem_r <= vme_wdata;
        end else begin
            vme_ack <= 1'b0;
            cnt_r   <= vme_req ? cnt_r + 4'h1 : 4'h0;
            if (ld)
                mem_r <= ld_val;
        end
    end
endmodule // vscg_vme_slave
